// >>> cpsm_pkg.sv
// Constants and types shared by the position setpoint block.
package cpsm_pkg;

  // Clock and millisecond base.
  localparam int unsigned CLK_PERIOD_NS  = 4;
  localparam int unsigned MS_NS          = 1000000;
  localparam int unsigned MS_CYCLES_DFLT = MS_NS / CLK_PERIOD_NS;

  // Operating mode selector codes.
  localparam logic [7:0] MODE_IP  = 8'h07;
  localparam logic [7:0] MODE_CSP = 8'h08;

  // Control word bit positions.
  localparam int CW_IP_EN = 4;
  localparam int CW_HALT  = 8;

  // Status word bit positions.
  localparam int SW_SYNC     = 8;
  localparam int SW_REACHED  = 10;
  localparam int SW_LIMIT    = 11;
  localparam int SW_ACTIVE   = 12;
  localparam int SW_FOLLOW   = 13;

  // Buffer enable value and the only supported time index (minus three).
  localparam logic [7:0] BUF_EN_VAL  = 8'h01;
  localparam logic [7:0] TIME_IDX_MS = 8'hFD;

  // Halt deceleration select codes; any other code uses the profile deceleration.
  localparam logic [1:0] HALT_OPT_QUICK = 2'h2;
  localparam logic [1:0] HALT_OPT_MAX   = 2'h3;

  // Sync is declared lost after this many cycle periods without a SYNC edge.
  localparam logic [9:0] SYNC_LOSS_PERIODS = 10'h002;

  localparam int unsigned FIFO_DEPTH_DFLT = 32;

  typedef enum logic [1:0] {MD_IDLE, MD_IP, MD_CSP} cpsm_mode_t;

endpackage

// >>> cpsm_setpoint.sv
// Position setpoint engine for interpolated and cyclic synchronous position modes, with its target FIFO.
`timescale 1ns/1ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
// Target FIFO; DEPTH must be a power of two so the pointers wrap naturally.
module cpsm_fifo #(
  parameter int unsigned W     = 32,
  parameter int unsigned DEPTH = 32
) (
  input  wire logic         mclk_i,
  input  wire logic         rst_i,
  input  wire logic         in_valid_i,
  input  wire logic [W-1:0] in_data_i,
  output logic              in_ready_o,
  output logic              out_valid_o,
  output logic [W-1:0]      out_data_o,
  input  wire logic         out_ready_i
);
  localparam int unsigned AW = $clog2(DEPTH);

  logic [W-1:0]  mem [DEPTH];
  logic [AW-1:0] wr_ptr_ff;
  logic [AW-1:0] rd_ptr_ff;
  logic [AW:0]   count_ff;
  logic [AW:0]   nxt_count;
  logic          in_ready_ff;
  wire           push = in_valid_i & in_ready_ff;
  wire           pop  = out_valid_o & out_ready_i;

  // Ready is registered from the next count, so it falls in the same cycle that the FIFO becomes full.
  assign nxt_count   = (AW+1)'(count_ff + (AW+1)'(push) - (AW+1)'(pop));
  assign in_ready_o  = in_ready_ff;
  assign out_valid_o = (count_ff != '0);
  assign out_data_o  = mem[rd_ptr_ff];

  // Pointer and occupancy bookkeeping.
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      wr_ptr_ff   <= '0;
      rd_ptr_ff   <= '0;
      count_ff    <= '0;
      in_ready_ff <= 1'b0;
    end else begin
      wr_ptr_ff   <= wr_ptr_ff + AW'(push);
      rd_ptr_ff   <= rd_ptr_ff + AW'(pop);
      count_ff    <= nxt_count;
      in_ready_ff <= (nxt_count != (AW+1)'(DEPTH));
    end
  end

  // Storage has no reset; only written words are ever read.
  always_ff @(posedge mclk_i) begin
    if (push) begin
      mem[wr_ptr_ff] <= in_data_i;
    end
  end
endmodule

////////////////////////////////////////////////////////////////////////////////
// Setpoint engine top level.
module cpsm_setpoint
  import cpsm_pkg::*;
#(
  parameter int unsigned POS_W      = 32,
  parameter int unsigned FIFO_DEPTH = FIFO_DEPTH_DFLT,
  parameter int unsigned MS_CYCLES  = MS_CYCLES_DFLT
) (
  input  wire logic             mclk_i,
  input  wire logic             rst_i,
  input  wire logic             mode_wr_i,
  input  wire logic [7:0]       mode_val_i,
  input  wire logic [15:0]      ctrl_word_i,
  input  wire logic             buf_cfg_wr_i,
  input  wire logic [7:0]       buf_cfg_val_i,
  input  wire logic [7:0]       period_ms_i,
  input  wire logic [7:0]       time_index_i,
  input  wire logic [1:0]       halt_opt_i,
  input  wire logic [POS_W-1:0] profile_decel_i,
  input  wire logic [POS_W-1:0] quick_decel_i,
  input  wire logic [POS_W-1:0] max_decel_i,
  input  wire logic [POS_W-1:0] start_accel_i,
  input  wire logic [POS_W-1:0] max_prof_vel_i,
  input  wire logic [POS_W-1:0] max_motor_speed_i,
  input  wire logic             closed_loop_i,
  input  wire logic             op_enabled_i,
  input  wire logic             nmt_operational_i,
  input  wire logic             sync_pin_i,
  input  wire logic             tgt_valid_i,
  input  wire logic [POS_W-1:0] tgt_pos_i,
  output logic                  tgt_ready_o,
  input  wire logic [POS_W-1:0] actual_pos_i,
  input  wire logic [POS_W-1:0] fe_window_i,
  input  wire logic [15:0]      fe_timeout_ms_i,
  input  wire logic [POS_W-1:0] sw_min_i,
  input  wire logic [POS_W-1:0] sw_max_i,
  output logic [POS_W-1:0]      demand_pos_o,
  output logic [15:0]           status_word_o,
  output logic                  interp_running_flag_o,
  output logic                  time_base_err_o
);
  localparam int unsigned MSW = $clog2(MS_CYCLES);
  localparam logic [MSW-1:0] MS_LAST = MSW'(MS_CYCLES - 1);

  typedef logic signed [POS_W-1:0] cpsm_pos_t;

  // Moves cur toward goal by at most rate.
  function automatic cpsm_pos_t cpsm_approach(cpsm_pos_t cur, cpsm_pos_t goal, cpsm_pos_t rate);
    cpsm_pos_t r;
    if (cur < goal) begin
      r = ((goal - cur) > rate) ? cur + rate : goal;
    end else begin
      r = ((cur - goal) > rate) ? cur - rate : goal;
    end
    return r;
  endfunction

  // Limits a signed value to plus or minus lim.
  function automatic cpsm_pos_t cpsm_clamp(cpsm_pos_t v, cpsm_pos_t lim);
    cpsm_pos_t r;
    r = v;
    if (v > lim) begin
      r = lim;
    end else if (v < -lim) begin
      r = -lim;
    end
    return r;
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // Registers.
  logic [2:0]     sync_sh_ff;
  logic           sync_lvl_ff;
  logic [MSW-1:0] ms_cnt_ff;
  logic           ms_tick_ff;
  logic [7:0]     cyc_ms_ff;
  logic           synced_ff;
  logic [9:0]     since_sync_ff;
  cpsm_mode_t     mode_ff;
  logic           buf_en_ff;
  logic           halt_ff;
  logic           slot_full_ff;
  cpsm_pos_t      slot_pos_ff;
  cpsm_pos_t      seg_end_ff;
  logic [7:0]     rem_ff;
  cpsm_pos_t      vel_ff;
  cpsm_pos_t      demand_ff;
  cpsm_pos_t      csp_tgt_ff;
  logic [15:0]    fe_cnt_ff;
  logic           fe_flag_ff;
  logic [15:0]    status_ff;
  logic           running_ff;
  logic           tb_err_ff;

  //////////////////////////////////////////////////////////////////////////////
  // SYNC pin: three flops, a rise to high counts once the last two agree.
  wire sync_agree = (sync_sh_ff[1] == sync_sh_ff[2]);
  wire sync_rise  = sync_agree & sync_sh_ff[2] & ~sync_lvl_ff;
  wire sync_ev    = sync_rise & nmt_operational_i;

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      sync_sh_ff  <= '0;
      sync_lvl_ff <= 1'b0;
    end else begin
      sync_sh_ff  <= {sync_sh_ff[1:0], sync_pin_i};
      sync_lvl_ff <= sync_agree ? sync_sh_ff[2] : sync_lvl_ff;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Millisecond base, phase locked to SYNC, and the cycle counter on top of it.
  wire       tb_ok       = (time_index_i == TIME_IDX_MS) && (period_ms_i != 8'h00);
  wire       cyc_last    = (cyc_ms_ff + 8'h01 >= period_ms_i);
  wire       cycle_start = synced_ff ? sync_ev : (ms_tick_ff & cyc_last & tb_ok);
  wire [9:0] loss_limit  = 10'(10'(period_ms_i) * SYNC_LOSS_PERIODS);

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      ms_cnt_ff  <= '0;
      ms_tick_ff <= 1'b0;
      cyc_ms_ff  <= '0;
    end else begin
      ms_cnt_ff  <= (sync_ev || ms_cnt_ff == MS_LAST) ? '0 : ms_cnt_ff + MSW'(1);
      ms_tick_ff <= (ms_cnt_ff == MS_LAST) && !sync_ev;
      cyc_ms_ff  <= cycle_start ? 8'h00 : (ms_tick_ff ? cyc_ms_ff + 8'h01 : cyc_ms_ff);
    end
  end

  // Sync status: gained on a SYNC edge in operational state, lost on silence.
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      synced_ff     <= 1'b0;
      since_sync_ff <= '0;
    end else begin
      since_sync_ff <= sync_ev ? 10'h000 :
                       (ms_tick_ff && since_sync_ff != 10'h3FF) ? since_sync_ff + 10'h001 : since_sync_ff;
      if (sync_ev) begin
        synced_ff <= 1'b1;
      end else if (!nmt_operational_i || since_sync_ff > loss_limit) begin
        synced_ff <= 1'b0;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Mode selection and buffer enable configuration.
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      mode_ff   <= MD_IDLE;
      buf_en_ff <= 1'b0;
      halt_ff   <= 1'b0;
    end else begin
      if (mode_wr_i) begin
        unique case (mode_val_i)
          MODE_IP:  mode_ff <= MD_IP;
          MODE_CSP: mode_ff <= MD_CSP;
          default:  mode_ff <= MD_IDLE;
        endcase
      end
      if (buf_cfg_wr_i) begin
        buf_en_ff <= (buf_cfg_val_i == BUF_EN_VAL);
      end
      halt_ff <= ctrl_word_i[CW_HALT];
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Target FIFO; in interpolated mode it drains into the empty single slot, or discards targets while the buffer is disabled.
  logic      fifo_vld;
  cpsm_pos_t fifo_pos;
  wire md_ip  = (mode_ff == MD_IP);
  wire md_csp = (mode_ff == MD_CSP);
  wire ip_run = md_ip & ctrl_word_i[CW_IP_EN] & op_enabled_i & buf_en_ff & tb_ok;
  wire ip_load = md_ip & buf_en_ff & ~slot_full_ff;
  wire fifo_pop = md_ip ? (ip_load | ~buf_en_ff) : 1'b1;
  wire take_ip  = fifo_vld & ip_load;
  wire take_csp = fifo_vld & md_csp;
  wire consume  = cycle_start & ip_run & slot_full_ff;

  cpsm_fifo #(
    .W     (POS_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .mclk_i      (mclk_i),
    .rst_i       (rst_i),
    .in_valid_i  (tgt_valid_i),
    .in_data_i   (tgt_pos_i),
    .in_ready_o  (tgt_ready_o),
    .out_valid_o (fifo_vld),
    .out_data_o  (fifo_pos),
    .out_ready_i (fifo_pop)
  );

  // Slot and segment registers; a cycle start turns the slot into the new segment end, and outside
  // interpolated mode the segment end shadows demand so that entering the mode starts at rest.
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      slot_full_ff <= 1'b0;
      slot_pos_ff  <= '0;
      seg_end_ff   <= '0;
      rem_ff       <= '0;
      csp_tgt_ff   <= '0;
    end else begin
      slot_full_ff <= md_ip & ((slot_full_ff & ~consume) | take_ip);
      slot_pos_ff  <= take_ip ? fifo_pos : slot_pos_ff;
      seg_end_ff   <= !md_ip ? demand_ff : (consume ? slot_pos_ff : seg_end_ff);
      if (consume) begin
        rem_ff <= period_ms_i;
      end else if (ms_tick_ff && ip_run && rem_ff != 8'h00) begin
        rem_ff <= rem_ff - 8'h01;
      end
      csp_tgt_ff <= take_csp ? fifo_pos : csp_tgt_ff;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Velocity planning: linear step per millisecond, speed limit, halt ramps; once the interval is spent the
  // rest of the segment is covered at the limit, so a speed-limited axis still arrives.
  wire cpsm_pos_t seg_diff  = seg_end_ff - demand_ff;
  wire cpsm_pos_t step_raw  = (rem_ff == 8'h00) ? seg_diff : seg_diff / $signed({1'b0, rem_ff});
  wire cpsm_pos_t vlim_cl   = (max_prof_vel_i < max_motor_speed_i) ? max_prof_vel_i : max_motor_speed_i;
  wire cpsm_pos_t vlim_ol   = {1'b0, {(POS_W-1){1'b1}}};
  wire cpsm_pos_t vlim      = closed_loop_i ? vlim_cl : vlim_ol;
  wire cpsm_pos_t vel_goal  = (halt_ff || !ip_run) ? '0 : cpsm_clamp(step_raw, vlim);
  wire cpsm_pos_t halt_dec  = (halt_opt_i == HALT_OPT_QUICK) ? quick_decel_i :
                              (halt_opt_i == HALT_OPT_MAX)   ? max_decel_i : profile_decel_i;
  wire cpsm_pos_t vel_rate  = (halt_ff || !ip_run) ? halt_dec : start_accel_i;
  wire cpsm_pos_t nxt_vel   = cpsm_approach(vel_ff, vel_goal, vel_rate);
  wire            ip_land   = (seg_diff > 0) ? (nxt_vel >= seg_diff) : (seg_diff < 0 && nxt_vel <= seg_diff);
  // Demand position: interpolated steps land on the segment end rather than overshoot; cyclic mode jumps.
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      vel_ff    <= '0;
      demand_ff <= '0;
    end else if (!op_enabled_i) begin
      vel_ff    <= '0;
    end else if (md_csp) begin
      vel_ff    <= '0;
      demand_ff <= (cycle_start && tb_ok) ? csp_tgt_ff : demand_ff;
    end else if (md_ip && ms_tick_ff) begin
      vel_ff    <= ip_land ? '0 : nxt_vel;
      demand_ff <= ip_land ? seg_end_ff : demand_ff + nxt_vel;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Following error supervision, counted in milliseconds.
  wire cpsm_pos_t fe_diff = demand_ff - $signed(actual_pos_i);
  wire cpsm_pos_t fe_abs  = fe_diff[POS_W-1] ? -fe_diff : fe_diff;
  wire fe_out   = (fe_abs > $signed(fe_window_i));
  wire fe_watch = md_csp | (md_ip & closed_loop_i);

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      fe_cnt_ff  <= '0;
      fe_flag_ff <= 1'b0;
    end else if (!fe_watch || !fe_out) begin
      fe_cnt_ff  <= '0;
      fe_flag_ff <= 1'b0;
    end else if (ms_tick_ff) begin
      fe_cnt_ff  <= (fe_cnt_ff == 16'hFFFF) ? fe_cnt_ff : fe_cnt_ff + 16'h0001;
      fe_flag_ff <= (fe_cnt_ff >= fe_timeout_ms_i);
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Status word assembly; bits not owned here read zero.
  wire reached   = halt_ff ? (vel_ff == '0) : (demand_ff == seg_end_ff && !slot_full_ff);
  wire csp_follow = md_csp & op_enabled_i & tb_ok;
  wire lim_hit   = (demand_ff > $signed(sw_max_i)) || (demand_ff < $signed(sw_min_i));
  logic [15:0] nxt_status;

  always_comb begin
    nxt_status             = 16'h0000;
    nxt_status[SW_SYNC]    = md_csp & synced_ff;
    nxt_status[SW_REACHED] = md_ip & reached;
    nxt_status[SW_LIMIT]   = lim_hit;
    nxt_status[SW_ACTIVE]  = md_ip ? ip_run : csp_follow;
    nxt_status[SW_FOLLOW]  = fe_flag_ff;
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      status_ff  <= '0;
      running_ff <= 1'b0;
      tb_err_ff  <= 1'b0;
    end else begin
      status_ff  <= nxt_status;
      running_ff <= ip_run;
      tb_err_ff  <= ~tb_ok;
    end
  end

  assign demand_pos_o          = demand_ff;
  assign status_word_o         = status_ff;
  assign interp_running_flag_o = running_ff;
  assign time_base_err_o       = tb_err_ff;

  //////////////////////////////////////////////////////////////////////////////
  // Checks on the design's own behaviour.
  a_mode_ip_entry: assert property (@(posedge mclk_i) disable iff (rst_i)
    mode_wr_i && mode_val_i == MODE_IP |=> mode_ff == MD_IP)
    else $error("mode seven did not enter interpolated mode");
  a_mode_csp_entry: assert property (@(posedge mclk_i) disable iff (rst_i)
    mode_wr_i && mode_val_i == MODE_CSP |=> mode_ff == MD_CSP)
    else $error("mode eight did not enter cyclic mode");
  a_ip_active_bit4: assert property (@(posedge mclk_i) disable iff (rst_i)
    $past(md_ip) && status_ff[SW_ACTIVE] |-> $past(ctrl_word_i[CW_IP_EN]))
    else $error("interpolation active without control bit 4");
  a_halt_brakes: assert property (@(posedge mclk_i) disable iff (rst_i)
    halt_ff && ms_tick_ff && md_ip && op_enabled_i && vel_ff > 0 && halt_dec > 0 |=> vel_ff < $past(vel_ff))
    else $error("halt did not reduce speed");
  a_csp_no_ramp: assert property (@(posedge mclk_i) disable iff (rst_i)
    md_csp && op_enabled_i && cycle_start && tb_ok |=> demand_ff == $past(csp_tgt_ff))
    else $error("cyclic demand did not jump to the preset");
  a_disabled_still: assert property (@(posedge mclk_i) disable iff (rst_i)
    !op_enabled_i |=> vel_ff == '0 ##1 !op_enabled_i || vel_ff == '0 || ms_tick_ff || $past(ms_tick_ff))
    else $error("axis moved while not operation enabled");
  a_buf_refuse: assert property (@(posedge mclk_i) disable iff (rst_i)
    !buf_en_ff && !slot_full_ff |=> !slot_full_ff)
    else $error("target accepted before buffer enable");
  a_sync_bit: assert property (@(posedge mclk_i) disable iff (rst_i)
    status_ff[SW_SYNC] |-> $past(md_csp && synced_ff))
    else $error("sync bit set without cyclic sync");
  a_speed_limit: assert property (@(posedge mclk_i) disable iff (rst_i)
    closed_loop_i && md_ip && ms_tick_ff && !halt_ff && ip_run && vel_ff <= vlim && vel_ff >= -vlim
    |=> vel_ff <= $past(vlim) && vel_ff >= -$past(vlim))
    else $error("closed loop speed exceeded the limit");
  a_limit_flag: assert property (@(posedge mclk_i) disable iff (rst_i)
    lim_hit |=> status_ff[SW_LIMIT])
    else $error("limit bit missing while demand outside limits");

  c_ip_segment: cover property (@(posedge mclk_i) disable iff (rst_i) consume ##[1:20] ms_tick_ff && ip_run);
  c_csp_follow: cover property (@(posedge mclk_i) disable iff (rst_i) md_csp && synced_ff && cycle_start);
  c_fifo_full:  cover property (@(posedge mclk_i) disable iff (rst_i) tgt_valid_i && !tgt_ready_o);
  c_following:  cover property (@(posedge mclk_i) disable iff (rst_i) $rose(fe_flag_ff));
endmodule

`default_nettype wire

// >>> cpsm_host_model.sv
// Behavioural host controller that streams absolute targets and sends SYNC pulses.
`timescale 1ns/1ps
`default_nettype none

module cpsm_host_model #(
  parameter int unsigned SYNC_CYC = 40
) (
  input  wire logic        mclk_i,
  input  wire logic        sync_en_i,
  input  wire logic        tgt_ready_i,
  output logic             tgt_valid_o,
  output logic [31:0]      tgt_pos_o,
  output logic             sync_o
);
  int cnt = 0;

  ////////////////////////////////////////////////////////////////////////////////
  // SYNC goes out at a fixed interval; the counter runs free so the phase never drifts.
  always @(posedge mclk_i) begin
    cnt <= (cnt == SYNC_CYC - 1) ? 0 : cnt + 1;
    sync_o <= sync_en_i && (cnt < 4);
  end

  // Nothing is offered at time zero.
  initial begin
    tgt_valid_o = 1'b0;
    tgt_pos_o = 32'h0000_0000;
    sync_o = 1'b0;
  end

  // Holds one target until ready is seen, then shows the inverse so a stale value never looks valid.
  task automatic send(input logic [31:0] pos);
    @(posedge mclk_i);
    tgt_valid_o <= 1'b1;
    tgt_pos_o <= pos;
    do @(posedge mclk_i); while (tgt_ready_i !== 1'b1);
    tgt_valid_o <= 1'b0;
    tgt_pos_o <= ~pos;
  endtask
endmodule

`default_nettype wire

// >>> tb_top.sv
// Self-checking testbench of the position setpoint engine in both position modes.
`timescale 1ns/1ps
`default_nettype none

module tb_top
  import cpsm_pkg::*;
;
  localparam int MS = 20;
  logic mclk_i = 0, rst_i = 1, mode_wr_i = 0, buf_cfg_wr_i = 0, closed_loop_i = 0;
  logic op_enabled_i = 1, nmt_operational_i = 0, sync_en = 0;
  logic [7:0] mode_val_i = 8'h00, buf_cfg_val_i = 8'h00, period_ms_i = 8'h02, time_index_i = 8'hFD;
  logic [15:0] ctrl_word_i = 16'h0000, fe_timeout_ms_i = 16'h0002, status_word_o;
  logic [1:0] halt_opt_i = 2'h2;
  logic [31:0] profile_decel_i = 32'h4, quick_decel_i = 32'h8, max_decel_i = 32'h10, start_accel_i = 32'h4;
  logic [31:0] max_prof_vel_i = 32'hA, max_motor_speed_i = 32'h3E8, fe_window_i = 32'hA;
  logic [31:0] sw_min_i = 32'hFFFF_FF00, sw_max_i = 32'h1000, actual_pos_i = 32'h0, tgt_pos_i, demand_pos_o;
  logic sync_pin_i, tgt_valid_i, tgt_ready_o, interp_running_flag_o, time_base_err_o;
  logic [31:0] held_pos;
  int n_errors = 0, check_count = 0;

  cpsm_setpoint #(.MS_CYCLES(MS)) dut_u (
    .mclk_i, .rst_i, .mode_wr_i, .mode_val_i, .ctrl_word_i, .buf_cfg_wr_i, .buf_cfg_val_i,
    .period_ms_i, .time_index_i, .halt_opt_i, .profile_decel_i, .quick_decel_i, .max_decel_i,
    .start_accel_i, .max_prof_vel_i, .max_motor_speed_i, .closed_loop_i, .op_enabled_i,
    .nmt_operational_i, .sync_pin_i, .tgt_valid_i, .tgt_pos_i, .tgt_ready_o, .actual_pos_i,
    .fe_window_i, .fe_timeout_ms_i, .sw_min_i, .sw_max_i, .demand_pos_o, .status_word_o,
    .interp_running_flag_o, .time_base_err_o);

  cpsm_host_model #(.SYNC_CYC(2 * MS)) host_u (.mclk_i, .sync_en_i(sync_en), .tgt_ready_i(tgt_ready_o),
    .tgt_valid_o(tgt_valid_i), .tgt_pos_o(tgt_pos_i), .sync_o(sync_pin_i));

  ////////////////////////////////////////////////////////////////////////////////
  // The clock toggles every half period of 4 ns.
  initial begin
    forever #2 mclk_i = ~mclk_i;
  end

  // Compares one value and reports a mismatch at once.
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Waits whole milliseconds and steps past the edge so registered outputs have settled.
  task automatic wait_ms(input int n);
    repeat (n * MS) @(posedge mclk_i);
    #1;
  endtask

  // One-cycle write strobe of the operating_mode_selector or of buffer setting six.
  task automatic wr_cfg(input logic is_buf, input logic [7:0] v);
    @(posedge mclk_i);
    if (is_buf) begin
      buf_cfg_wr_i <= 1'b1;
      buf_cfg_val_i <= v;
    end else begin
      mode_wr_i <= 1'b1;
      mode_val_i <= v;
    end
    @(posedge mclk_i);
    buf_cfg_wr_i <= 1'b0;
    mode_wr_i <= 1'b0;
  endtask

  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // Main sequence; the period stays at 2 ms and the power stage stays enabled except for the disabled hold step.
  initial begin
    repeat (8) @(posedge mclk_i);
    rst_i <= 1'b0;
    wait_ms(1);
    check("status after reset", 32'h0, status_word_o);
    check("target ready", 1'b1, tgt_ready_o);
    @(posedge mclk_i);
    time_index_i <= 8'h00;
    wait_ms(1);
    check("bad time index", 1'b1, time_base_err_o);
    @(posedge mclk_i);
    time_index_i <= TIME_IDX_MS;
    wait_ms(1);
    check("good time index", 1'b0, time_base_err_o);
    wr_cfg(1'b0, MODE_CSP);
    host_u.send(32'h64);
    wait_ms(3);
    check("cyclic demand", 32'h64, demand_pos_o);
    check("cyclic follows", 1'b1, status_word_o[SW_ACTIVE]);
    check("limit clear", 1'b0, status_word_o[SW_LIMIT]);
    repeat (3) host_u.send(32'h80);
    wait_ms(3);
    check("repeated target", 32'h80, demand_pos_o);
    wait_ms(4);
    check("target kept", 32'h80, demand_pos_o);
    check("following error", 1'b1, status_word_o[SW_FOLLOW]);
    @(posedge mclk_i);
    actual_pos_i <= 32'h80;
    sw_max_i <= 32'h70;
    wait_ms(1);
    check("following error clear", 1'b0, status_word_o[SW_FOLLOW]);
    check("limit exceeded", 1'b1, status_word_o[SW_LIMIT]);
    @(posedge mclk_i);
    sw_max_i <= 32'h1000;
    nmt_operational_i <= 1'b1;
    sync_en <= 1'b1;
    wait_ms(6);
    check("in sync", 1'b1, status_word_o[SW_SYNC]);
    @(posedge mclk_i);
    sync_en <= 1'b0;
    wait_ms(6);
    check("sync lost", 1'b0, status_word_o[SW_SYNC]);
    @(posedge mclk_i);
    closed_loop_i <= 1'b1;
    ctrl_word_i <= 16'h0010;
    wr_cfg(1'b0, MODE_IP);
    host_u.send(32'h200);
    wait_ms(4);
    check("target before enable", 32'h80, demand_pos_o);
    wr_cfg(1'b1, BUF_EN_VAL);
    wait_ms(1);
    check("interp running", 1'b1, interp_running_flag_o);
    check("interp status", 1'b1, status_word_o[SW_ACTIVE]);
    host_u.send(32'hC8);
    wait_ms(4);
    check("speed limited", 1'b1, demand_pos_o < 32'hC8 && demand_pos_o > 32'h80);
    wait_ms(20);
    check("segment end", 32'hC8, demand_pos_o);
    check("target reached", 1'b1, status_word_o[SW_REACHED]);
    check("ip following error", 1'b1, status_word_o[SW_FOLLOW]);
    // A second segment is halted mid-way, held while the power stage is off, then resumed.
    host_u.send(32'h12C);
    wait_ms(4);
    @(posedge mclk_i);
    ctrl_word_i <= 16'h0110;
    wait_ms(4);
    held_pos = demand_pos_o;
    check("halt before target", 1'b1, held_pos < 32'h12C && held_pos > 32'hC8);
    check("halt standstill", 1'b1, status_word_o[SW_REACHED]);
    @(posedge mclk_i);
    ctrl_word_i <= 16'h0010;
    op_enabled_i <= 1'b0;
    wait_ms(2);
    check("disabled hold", held_pos, demand_pos_o);
    @(posedge mclk_i);
    op_enabled_i <= 1'b1;
    wait_ms(20);
    check("resume after halt", 32'h12C, demand_pos_o);
    @(posedge mclk_i);
    ctrl_word_i <= 16'h0000;
    wait_ms(1);
    check("interp stopped", 1'b0, interp_running_flag_o);
    report_and_stop();
  end

  // A hang is cut short well after the roughly 1760 cycles the sequence needs.
  initial begin
    repeat (6000) @(posedge mclk_i);
    n_errors++;
    report_and_stop();
  end
endmodule

`default_nettype wire
